// file: urf_pkg.sv
// Package of constants for the UART receive buffer and flow-control block.
package urf_pkg;
   // ****************************************
   // Register indices (host register port)
   // ****************************************
   localparam logic [3:0] URF_A_RXH = 4'h0;
   localparam logic [3:0] URF_A_IER = 4'h1;
   localparam logic [3:0] URF_A_FCR = 4'h2;
   localparam logic [3:0] URF_A_LCR = 4'h3;
   localparam logic [3:0] URF_A_MCR = 4'h4;
   localparam logic [3:0] URF_A_LSR = 4'h5;
   localparam logic [3:0] URF_A_ISR = 4'h6;
   localparam logic [3:0] URF_A_EFR = 4'h7;
   localparam logic [3:0] URF_A_ON1 = 4'h8;
   localparam logic [3:0] URF_A_ON2 = 4'h9;
   localparam logic [3:0] URF_A_OF1 = 4'hA;
   localparam logic [3:0] URF_A_OF2 = 4'hB;
   localparam logic [3:0] URF_A_LVL = 4'hC;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int URF_FCR_EN = 0;
   localparam int URF_MCR_RTS = 1;
   localparam int URF_EFR_ENH = 4;
   localparam int URF_EFR_SPC = 5;
   localparam int URF_EFR_ARTS = 6;
   localparam int URF_EFR_ACTS = 7;
   localparam int URF_IER_PAUSE = 5;
   localparam int URF_IER_RTS = 6;
   localparam int URF_IER_CTS = 7;
   localparam int URF_ISR_CHR = 4;
   localparam int URF_ISR_FLOW = 5;
   localparam int URF_LSR_TAG = 2;
   // ****************************************
   // Sizes and reset values
   // ****************************************
   localparam int URF_DEPTH = 128;
   localparam int URF_AW = 7;
   localparam int URF_EW = 11;
   localparam logic [7:0] URF_RST8 = 8'h00;
   // Two character times at the slowest framing of 12 bits per character.
   localparam int URF_BITS_2CHR = 24;
   typedef enum logic [1:0] {URF_SW_OFF, URF_SW_SINGLE, URF_SW_DOUBLE} urf_sw_t;
   typedef enum {URF_TX_IDLE, URF_TX_WAIT, URF_TX_C1, URF_TX_C2} urf_txs_t;
endpackage : urf_pkg

// file: urf_fifo.sv
// Receive storage: 128 entries of data byte plus three error tags.
`timescale 1ns/100ps
`default_nettype none
module urf_fifo
   import urf_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic clr_i,
   input wire logic wr_i,
   input wire logic [URF_EW-1:0] wdata_i,
   input wire logic rd_i,
   output logic [URF_EW-1:0] head_o,
   output logic [URF_AW:0] count_o
);
   // ****************************************
   // Storage
   // ****************************************
   logic [URF_EW-1:0] mem [URF_DEPTH];
   logic [URF_AW-1:0] wp_r;
   logic [URF_AW-1:0] rp_r;
   logic [URF_AW:0] cnt_r;
   logic do_wr;
   logic do_rd;
   assign do_wr = wr_i && (cnt_r != URF_AW'(0) + (URF_AW+1)'(URF_DEPTH));
   assign do_rd = rd_i && (cnt_r != '0);
   assign head_o = mem[rp_r];
   assign count_o = cnt_r;
   always_ff @(posedge REF_CLK_I) begin
      if (do_wr) begin
         mem[wp_r] <= wdata_i;
      end
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (clr_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_wr) begin
            wp_r <= wp_r + 1'b1;
         end
         if (do_rd) begin
            rp_r <= rp_r + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule : urf_fifo
`default_nettype wire

// file: urf_top.sv
// Receive holding path, hardware and character flow control of a UART.
`timescale 1ns/100ps
`default_nettype none
module urf_top
   import urf_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] WDATA_I,
   output logic [7:0] RDATA_O,
   input wire logic RX_VALID_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic [2:0] RX_ERR_I,
   input wire logic [1:0] SW_MODE_I,
   input wire logic [7:0] TRIG_LVL_I,
   input wire logic [7:0] UPPER_LVL_I,
   input wire logic [7:0] LOWER_LVL_I,
   input wire logic BIT_TICK_I,
   input wire logic CTS_N_I,
   input wire logic TX_CHAR_DONE_I,
   input wire logic FC_TX_READY_I,
   output logic RTS_N_O,
   output logic TX_HALT_O,
   output logic FC_TX_VALID_O,
   output logic [7:0] FC_TX_DATA_O,
   output logic RX_TRIG_O,
   output logic INT_O
);
   // ****************************************
   // Registers and synchronisers
   // ****************************************
   logic [7:0] ier_r, fcr_r, lcr_r, mcr_r, efr_r;
   logic [7:0] on1_r, on2_r, of1_r, of2_r;
   logic chr_flag_r, flow_flag_r;
   logic [1:0] cts_s_r;
   logic cts_r;
   logic cts_stop_r, pause_r, half_r, rts_r, rts_prev_r;
   logic [7:0] rd_data_r;
   logic [URF_EW-1:0] head;
   logic [URF_AW:0] fill;
   logic [7:0] wmask;
   logic hit_on1, hit_on2, hit_of1, hit_of2;
   logic pause_ev, resume_ev, consume, spc_hit;
   logic wr_fifo, rd_pop;
   logic [4:0] bit_cnt_r;
   logic sent_r;
   urf_txs_t txs_r;
   urf_sw_t sw;

   function automatic logic [7:0] len_mask(input logic [1:0] wl);
      len_mask = 8'hFF >> (3'(3) - 3'(wl));
   endfunction
   function automatic logic cmp(input logic [7:0] a, input logic [7:0] b,
                                input logic [7:0] m);
      cmp = ((a ^ b) & m) == 8'h00;
   endfunction

   assign sw = urf_sw_t'(SW_MODE_I);
   assign wmask = len_mask(lcr_r[1:0]);
   assign hit_on1 = cmp(RX_DATA_I, on1_r, wmask);
   assign hit_on2 = cmp(RX_DATA_I, on2_r, wmask);
   assign hit_of1 = cmp(RX_DATA_I, of1_r, wmask);
   assign hit_of2 = cmp(RX_DATA_I, of2_r, wmask);

   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cts_s_r <= 2'b11;
         cts_r <= 1'b1;
      end else begin
         cts_s_r <= {cts_s_r[0], CTS_N_I};
         cts_r <= cts_s_r[1];
      end
   end

   // ****************************************
   // Host register port
   // ****************************************
   // reset clears characters
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ier_r <= URF_RST8;
         fcr_r <= URF_RST8;
         lcr_r <= URF_RST8;
         mcr_r <= URF_RST8;
         efr_r <= URF_RST8;
         on1_r <= URF_RST8;
         on2_r <= URF_RST8;
         of1_r <= URF_RST8;
         of2_r <= URF_RST8;
      end else if (WR_I) begin
         case (ADDR_I)
            URF_A_IER: ier_r <= efr_r[URF_EFR_ENH] ? WDATA_I : {3'b000, WDATA_I[4:0]};
            URF_A_FCR: fcr_r <= WDATA_I;
            URF_A_LCR: lcr_r <= WDATA_I;
            URF_A_MCR: mcr_r <= WDATA_I;
            URF_A_EFR: efr_r <= WDATA_I;
            URF_A_ON1: on1_r <= WDATA_I;
            URF_A_ON2: on2_r <= WDATA_I;
            URF_A_OF1: of1_r <= WDATA_I;
            URF_A_OF2: of2_r <= WDATA_I;
            default: begin
            end
         endcase
      end
   end

   assign rd_pop = RD_I && (ADDR_I == URF_A_RXH);
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rd_data_r <= 8'h00;
      end else if (RD_I) begin
         case (ADDR_I)
            URF_A_RXH: rd_data_r <= head[7:0];
            URF_A_IER: rd_data_r <= ier_r;
            URF_A_FCR: rd_data_r <= fcr_r;
            URF_A_LCR: rd_data_r <= lcr_r;
            URF_A_MCR: rd_data_r <= mcr_r;
            URF_A_LSR: rd_data_r <= {3'b000, head[10:8], 1'b0, fill != '0};
            URF_A_ISR: rd_data_r <= {2'b00, flow_flag_r, chr_flag_r, 4'h0};
            URF_A_EFR: rd_data_r <= efr_r;
            URF_A_ON1: rd_data_r <= on1_r;
            URF_A_ON2: rd_data_r <= on2_r;
            URF_A_OF1: rd_data_r <= of1_r;
            URF_A_OF2: rd_data_r <= of2_r;
            URF_A_LVL: rd_data_r <= 8'(fill);
            default: rd_data_r <= 8'h00;
         endcase
      end
   end
   assign RDATA_O = rd_data_r;

   // ****************************************
   // Character matching
   // ****************************************
   // double match sequencing
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         half_r <= 1'b0;
      end else if (RX_VALID_I) begin
         half_r <= (sw == URF_SW_DOUBLE) && !half_r && (hit_of1 || (pause_r && hit_on1));
      end
   end
   assign pause_ev = RX_VALID_I && ((sw == URF_SW_SINGLE) ? (hit_of1 || hit_of2) :
                     (sw == URF_SW_DOUBLE) ? (half_r && hit_of2) : 1'b0);
   assign resume_ev = RX_VALID_I && pause_r && ((sw == URF_SW_SINGLE) ? (hit_on1 || hit_on2) :
                      (sw == URF_SW_DOUBLE) ? (half_r && hit_on2) : 1'b0);
   assign spc_hit = RX_VALID_I && efr_r[URF_EFR_SPC] && hit_of2;
   assign consume = (sw != URF_SW_OFF) && !efr_r[URF_EFR_SPC] &&
                    (pause_ev || resume_ev ||
                     (sw == URF_SW_DOUBLE && RX_VALID_I && (hit_of1 || hit_on1)));
   assign wr_fifo = RX_VALID_I && !consume;

   urf_fifo u_fifo (
      .REF_CLK_I(REF_CLK_I),
      .RST_I(RST_I),
      .clr_i(!fcr_r[URF_FCR_EN]),
      .wr_i(wr_fifo),
      .wdata_i({RX_ERR_I, RX_DATA_I}),
      .rd_i(rd_pop),
      .head_o(head),
      .count_o(fill)
   );

   // ****************************************
   // Transmit suspension
   // ****************************************
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pause_r <= 1'b0;
      end else if (resume_ev) begin
         pause_r <= 1'b0;
      end else if (pause_ev && !efr_r[URF_EFR_SPC]) begin
         pause_r <= 1'b1;
      end
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cts_stop_r <= 1'b0;
      end else if (!efr_r[URF_EFR_ACTS] || !cts_r) begin
         cts_stop_r <= 1'b0;
      end else if (TX_CHAR_DONE_I || !TX_HALT_O) begin
         cts_stop_r <= 1'b1;
      end
   end
   assign TX_HALT_O = cts_stop_r || pause_r;

   // ****************************************
   // Status flags
   // ****************************************
   // pause flag, set beats clear
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         chr_flag_r <= 1'b0;
      end else if ((pause_ev && ier_r[URF_IER_PAUSE]) || spc_hit) begin
         chr_flag_r <= 1'b1;
      end else if (resume_ev || (RD_I && ADDR_I == URF_A_ISR)) begin
         chr_flag_r <= 1'b0;
      end
   end
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         flow_flag_r <= 1'b0;
         rts_prev_r <= 1'b1;
      end else begin
         rts_prev_r <= RTS_N_O;
         if ((ier_r[URF_IER_RTS] && RTS_N_O && !rts_prev_r) ||
             (ier_r[URF_IER_CTS] && cts_s_r[1] && !cts_r)) begin
            flow_flag_r <= 1'b1;
         end else if (RD_I && ADDR_I == URF_A_ISR) begin
            flow_flag_r <= 1'b0;
         end
      end
   end
   assign RX_TRIG_O = fcr_r[URF_FCR_EN] && (fill >= (URF_AW+1)'(TRIG_LVL_I));
   assign INT_O = chr_flag_r || flow_flag_r || RX_TRIG_O;

   // ****************************************
   // Request-to-send hysteresis
   // ****************************************
   // upper and lower levels
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rts_r <= 1'b0;
      end else if (fill >= (URF_AW+1)'(UPPER_LVL_I)) begin
         rts_r <= 1'b1;
      end else if (fill <= (URF_AW+1)'(LOWER_LVL_I)) begin
         rts_r <= 1'b0;
      end
   end
   assign RTS_N_O = !mcr_r[URF_MCR_RTS] || (efr_r[URF_EFR_ARTS] && rts_r);

   // ****************************************
   // Pause and resume character sender
   // ****************************************
   // delay after crossing
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         txs_r <= URF_TX_IDLE;
         bit_cnt_r <= '0;
         sent_r <= 1'b0;
         FC_TX_DATA_O <= 8'h00;
      end else begin
         case (txs_r)
            URF_TX_IDLE: begin
               bit_cnt_r <= '0;
               if (sw != URF_SW_OFF && !sent_r && RX_TRIG_O) begin
                  txs_r <= URF_TX_WAIT;
               end else if (sent_r && fill <= (URF_AW+1)'(LOWER_LVL_I)) begin
                  txs_r <= URF_TX_C1;
                  sent_r <= 1'b0;
                  FC_TX_DATA_O <= on1_r;
               end
            end
            URF_TX_WAIT: begin
               if (BIT_TICK_I) begin
                  bit_cnt_r <= bit_cnt_r + 1'b1;
               end
               if (bit_cnt_r == 5'(URF_BITS_2CHR)) begin
                  txs_r <= URF_TX_C1;
                  sent_r <= 1'b1;
                  FC_TX_DATA_O <= of1_r;
               end
            end
            URF_TX_C1: begin
               if (FC_TX_READY_I) begin
                  txs_r <= (sw == URF_SW_DOUBLE) ? URF_TX_C2 : URF_TX_IDLE;
                  FC_TX_DATA_O <= sent_r ? of2_r : on2_r;
               end
            end
            URF_TX_C2: begin
               if (FC_TX_READY_I) begin
                  txs_r <= URF_TX_IDLE;
               end
            end
            default: txs_r <= URF_TX_IDLE;
         endcase
      end
   end
   assign FC_TX_VALID_O = (txs_r == URF_TX_C1) || (txs_r == URF_TX_C2);
endmodule : urf_top
`default_nettype wire

// file: urf_monitor.sv
// Port checker of the UART receive buffer and flow-control block.
`timescale 1ns/100ps
`default_nettype none
module urf_monitor
   import urf_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] WDATA_I,
   input wire logic [7:0] RDATA_O,
   input wire logic CTS_N_I,
   input wire logic TX_CHAR_DONE_I,
   input wire logic FC_TX_READY_I,
   input wire logic RTS_N_O,
   input wire logic TX_HALT_O,
   input wire logic FC_TX_VALID_O,
   input wire logic [7:0] FC_TX_DATA_O,
   input wire logic RX_TRIG_O,
   input wire logic INT_O
);
   logic [7:0] efr_r;
   logic mcr_r;
   // Shadow copies, because these control bits never appear at the ports.
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         efr_r <= 8'h00;
         mcr_r <= 1'b0;
      end else if (WR_I && ADDR_I == URF_A_EFR) begin
         efr_r <= WDATA_I;
      end else if (WR_I && ADDR_I == URF_A_MCR) begin
         mcr_r <= WDATA_I[URF_MCR_RTS];
      end
   end
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);
   chk_reset_quiet: assert property (disable iff (1'b0) RST_I |-> RTS_N_O && !INT_O)
      else $error("outputs active in reset");
   chk_rts_start: assert property (!mcr_r |-> RTS_N_O)
      else $error("request-to-send low before start");
   chk_ier_guard: assert property ((WR_I && ADDR_I == URF_A_IER && !efr_r[URF_EFR_ENH])
      ##2 (RD_I && ADDR_I == URF_A_IER) |=> RDATA_O[7:5] == 3'h0)
      else $error("guarded enable bits written");
   chk_read_stands: assert property (!RD_I |=> $stable(RDATA_O))
      else $error("read data changed without read");
   chk_unmapped_zero: assert property (RD_I && ADDR_I == 4'hF |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   chk_trig_int: assert property (RX_TRIG_O |-> INT_O)
      else $error("trigger without interrupt");
   chk_fc_hold: assert property (FC_TX_VALID_O && !FC_TX_READY_I |=> FC_TX_VALID_O && $stable(FC_TX_DATA_O))
      else $error("flow character dropped before taken");
   chk_cts_halt: assert property ((efr_r[URF_EFR_ACTS] && CTS_N_I) [*4]
      ##1 (CTS_N_I && TX_CHAR_DONE_I) |-> ##[1:3] TX_HALT_O)
      else $error("no halt after clear-to-send high");
   cov_rts_off: cover property ($rose(RTS_N_O));
   cov_halt: cover property ($rose(TX_HALT_O));
   cov_fc_send: cover property (FC_TX_VALID_O && FC_TX_READY_I);
endmodule // urf_monitor
bind urf_top urf_monitor u_urf_monitor (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .CTS_N_I(CTS_N_I),
   .TX_CHAR_DONE_I(TX_CHAR_DONE_I), .FC_TX_READY_I(FC_TX_READY_I), .RTS_N_O(RTS_N_O),
   .TX_HALT_O(TX_HALT_O), .FC_TX_VALID_O(FC_TX_VALID_O), .FC_TX_DATA_O(FC_TX_DATA_O),
   .RX_TRIG_O(RX_TRIG_O), .INT_O(INT_O));
`default_nettype wire

// file: urf_partner.sv
// Model of the remote UART: sends characters, takes flow-control characters.
`timescale 1ns/100ps
`default_nettype none
module urf_partner (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [10:0] chr_i,
   input wire logic slow_i,
   input wire logic fc_valid_i,
   input wire logic [7:0] fc_data_i,
   output logic rx_valid_o,
   output logic [10:0] rx_chr_o,
   output logic fc_ready_o,
   output logic [7:0] fc_last_o,
   output logic [7:0] fc_cnt_o
);
   logic [1:0] div_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_valid_o <= 1'b0;
         rx_chr_o <= 11'h000;
      end else begin
         rx_valid_o <= go_i;
         // Between characters the data toggles, so a stale byte cannot pass.
         rx_chr_o <= go_i ? chr_i : ~rx_chr_o;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 2'h0;
         fc_last_o <= 8'h00;
         fc_cnt_o <= 8'h00;
      end else begin
         div_r <= div_r + 2'h1;
         if (fc_valid_i && fc_ready_o) begin
            fc_last_o <= fc_data_i;
            fc_cnt_o <= fc_cnt_o + 8'h01;
         end
      end
   end
   assign fc_ready_o = !slow_i || div_r == 2'h0;
endmodule // urf_partner
`default_nettype wire

// file: urf_top_bench.sv
// Self-checking testbench of the UART receive buffer and flow-control block.
`timescale 1ns/100ps
`default_nettype none
module urf_top_bench import urf_pkg::*; ;
   logic clk, rst, wr, rd, go, slow, cts_n, done, tick, rdy, rxv, rts_n, halt, fcv, trig, intr;
   logic [3:0] addr;
   logic [1:0] mode;
   logic [7:0] wdata, rdata, fcd, fcl, fcc, d, c0;
   logic [10:0] chr, rxc;
   int num_errors, comparisons, cyc, i;
   urf_top u_urf_top (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
      .WDATA_I(wdata), .RDATA_O(rdata), .RX_VALID_I(rxv), .RX_DATA_I(rxc[7:0]),
      .RX_ERR_I(rxc[10:8]), .SW_MODE_I(mode), .TRIG_LVL_I(8'h08), .UPPER_LVL_I(8'h10),
      .LOWER_LVL_I(8'h00), .BIT_TICK_I(tick), .CTS_N_I(cts_n), .TX_CHAR_DONE_I(done),
      .FC_TX_READY_I(rdy), .RTS_N_O(rts_n), .TX_HALT_O(halt), .FC_TX_VALID_O(fcv),
      .FC_TX_DATA_O(fcd), .RX_TRIG_O(trig), .INT_O(intr));
   urf_partner u_urf_partner (.clk_i(clk), .rst_i(rst), .go_i(go), .chr_i(chr), .slow_i(slow),
      .fc_valid_i(fcv), .fc_data_i(fcd), .rx_valid_o(rxv), .rx_chr_o(rxc), .fc_ready_o(rdy),
      .fc_last_o(fcl), .fc_cnt_o(fcc));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The cycle ceiling sits well above the roughly 1200 cycles the tests need.
   always @(posedge clk) begin
      tick <= ~tick;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_r(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
      ck(d & m, e);
   endtask
   task automatic snd(input logic [10:0] c, input logic pulse);
      @(posedge clk);
      go <= 1'b1;
      chr <= c;
      @(posedge clk);
      go <= 1'b0;
      done <= pulse;
      @(posedge clk);
      done <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   initial begin
      {wr, rd, go, slow, cts_n, done, tick} = 7'h00;
      {rst, addr, mode, wdata, chr, cyc, num_errors, comparisons} = '0;
      #1 rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (i = 8; i < 12; i++) begin
         rk(i[3:0], 8'hFF, 8'h00);
         wr_r(i[3:0], 8'hA0 + i[7:0]);
         rk(i[3:0], 8'hFF, 8'hA0 + i[7:0]);
      end
      rk(4'hF, 8'hFF, 8'h00);
      wr_r(URF_A_IER, 8'hFF);
      rk(URF_A_IER, 8'hFF, 8'h1F);
      $display("test registers done");
      wr_r(URF_A_FCR, 8'h01);
      snd(11'h141, 1'b0);
      snd(11'h442, 1'b0);
      rk(URF_A_LSR, 8'h1D, 8'h05);
      rk(URF_A_RXH, 8'hFF, 8'h41);
      rk(URF_A_LSR, 8'h1D, 8'h11);
      rk(URF_A_RXH, 8'hFF, 8'h42);
      rk(URF_A_LSR, 8'h01, 8'h00);
      $display("test store done");
      wr_r(URF_A_EFR, 8'h50);
      wr_r(URF_A_IER, 8'h40);
      wr_r(URF_A_MCR, 8'h02);
      rk(URF_A_ISR, 8'h00, 8'h00);
      for (i = 0; i < 130; i++) begin
         snd({3'h0, i[7:0]}, 1'b0);
         if (i == 14) ck({6'h00, rts_n, trig}, 8'h01);
         if (i == 15) ck({6'h00, rts_n, trig}, 8'h03);
      end
      rk(URF_A_ISR, 8'h20, 8'h20);
      rk(URF_A_LVL, 8'hFF, 8'h80);
      for (i = 0; i < 128; i++) begin
         rk(URF_A_RXH, 8'hFF, i[7:0]);
         if (i == 126) ck({7'h00, rts_n}, 8'h01);
      end
      @(posedge clk);
      #1 ck({7'h00, rts_n}, 8'h00);
      $display("test hardware flow done");
      wr_r(URF_A_EFR, 8'hD0);
      wr_r(URF_A_IER, 8'h80);
      @(posedge clk) cts_n <= 1'b1;
      repeat (4) @(posedge clk);
      snd(11'h000, 1'b1);
      ck({7'h00, halt}, 8'h01);
      rk(URF_A_ISR, 8'h20, 8'h20);
      @(posedge clk) cts_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1 ck({7'h00, halt}, 8'h00);
      rk(URF_A_RXH, 8'h00, 8'h00);
      $display("test clear-to-send done");
      wr_r(URF_A_EFR, 8'h10);
      wr_r(URF_A_OF1, 8'h13);
      wr_r(URF_A_ON1, 8'h11);
      wr_r(URF_A_IER, 8'h20);
      wr_r(URF_A_LCR, 8'h00);
      @(posedge clk) mode <= URF_SW_SINGLE;
      snd(11'h0F3, 1'b1);
      ck({6'h00, halt, intr}, 8'h03);
      rk(URF_A_LVL, 8'hFF, 8'h00);
      rk(URF_A_ISR, 8'h10, 8'h10);
      snd(11'h0D1, 1'b0);
      ck({7'h00, halt}, 8'h00);
      wr_r(URF_A_LCR, 8'h03);
      @(posedge clk) slow <= 1'b1;
      c0 = fcc;
      for (i = 0; i < 8; i++) snd({3'h0, 8'h20 + i[7:0]}, 1'b0);
      repeat (30) @(posedge clk);
      ck(fcc, c0);
      repeat (40) @(posedge clk);
      ck(fcl, 8'h13);
      for (i = 0; i < 8; i++) rk(URF_A_RXH, 8'hFF, 8'h20 + i[7:0]);
      repeat (10) @(posedge clk);
      ck({fcl[3:0], fcc[3:0] - c0[3:0]}, 8'h12);
      $display("test pause and resume done");
      @(posedge clk) mode <= URF_SW_DOUBLE;
      wr_r(URF_A_OF2, 8'h93);
      wr_r(URF_A_ON2, 8'h91);
      snd(11'h013, 1'b0);
      snd(11'h091, 1'b1);
      ck({7'h00, halt}, 8'h00);
      snd(11'h013, 1'b0);
      snd(11'h093, 1'b1);
      ck({7'h00, halt}, 8'h01);
      snd(11'h011, 1'b0);
      snd(11'h091, 1'b0);
      ck({7'h00, halt}, 8'h00);
      @(posedge clk) mode <= URF_SW_OFF;
      wr_r(URF_A_EFR, 8'h30);
      rk(URF_A_LVL, 8'h00, 8'h00);
      c0 = d;
      rk(URF_A_ISR, 8'h00, 8'h00);
      snd(11'h093, 1'b0);
      rk(URF_A_LVL, 8'hFF, c0 + 8'h01);
      rk(URF_A_ISR, 8'h10, 8'h10);
      $display("test double and special done");
      results();
   end
endmodule // urf_top_bench
`default_nettype wire
